// *** verilog/oag_pkg.sv ***
// Purpose: Shared constants and types for the operand address generator.
// Assumes: 16-bit address space, 8-bit immediates.
// Notes:   All windows are inclusive bounds.
package oag_pkg;

  // ****************************************
  // Address windows
  // ****************************************
  localparam logic [15:0] SHORT_LO_SMALL = 16'hFE80;
  localparam logic [15:0] SHORT_LO_LARGE = 16'hFE20;
  localparam logic [15:0] SHORT_HI       = 16'hFF1F;
  localparam logic [15:0] FAST_RAM_HI    = 16'hFEFF;
  localparam logic [7:0]  SHORT_PAGE_HI  = 8'hFF;
  localparam logic [6:0]  SHORT_UPPER    = 7'h7F;
  localparam logic [7:0]  SFR_PAGE       = 8'hFF;
  localparam logic [7:0]  SHORT_SFR_LIM  = 8'h1F;
  localparam int          ADDR_BIT8      = 8;

  // ****************************************
  // Decoding
  // ****************************************
  localparam logic [7:0]  OPC_LOAD_ACC_PTR = 8'h2B;
  localparam logic [1:0]  PAIR_ACCUM       = 2'h0;
  localparam logic [1:0]  PAIR_COUNTER     = 2'h1;
  localparam logic [1:0]  PAIR_POINTER     = 2'h2;
  localparam logic [1:0]  PAIR_BASE        = 2'h3;
  localparam logic [15:0] ADDR_RST         = 16'h0000;
  localparam logic [2:0]  REG_RST          = 3'h0;
  localparam logic [15:0] STACK_STEP       = 16'h0001;

  typedef enum logic [2:0] {
    MODE_SHORT   = 3'b000,
    MODE_SFR     = 3'b001,
    MODE_REG     = 3'b010,
    MODE_INDIR   = 3'b011,
    MODE_BASED   = 3'b100,
    MODE_STACK   = 3'b101
  } oag_mode_t;

  typedef enum logic [2:0] {
    STK_PUSH     = 3'b000,
    STK_POP      = 3'b001,
    STK_CALL     = 3'b010,
    STK_RET      = 3'b011,
    STK_INT_SAVE = 3'b100,
    STK_INT_REST = 3'b101
  } oag_stack_t;

endpackage

// *** verilog/oag_short_if.sv ***
// Purpose: Carries short direct request and result between core and former.
// Assumes: Purely combinational exchange on one clock.
// Notes:   None.
interface oag_short_if;
  logic [7:0]  immByte;
  logic        smallVariant;
  logic        wordOp;
  logic [15:0] shortAddr;
  logic        inWindow;
  logic        aligned;

  modport former (
    input  immByte,
    input  smallVariant,
    input  wordOp,
    output shortAddr,
    output inWindow,
    output aligned
  );

  modport user (
    output immByte,
    output smallVariant,
    output wordOp,
    input  shortAddr,
    input  inWindow,
    input  aligned
  );
endinterface

// *** verilog/oag_short_former.sv ***
// Purpose: Forms the short direct effective address and checks its window.
// Assumes: Caller registers the results.
// Notes:   Combinational only.
module oag_short_former (
  oag_short_if.former sif
);

  logic [15:0] addr;
  logic [15:0] windowLo;

  always_comb begin
    // Low immediates land in the first register page, the rest in fast RAM
    addr[15:9] = oag_pkg::SHORT_UPPER;
    addr[oag_pkg::ADDR_BIT8] = (sif.immByte <= oag_pkg::SHORT_SFR_LIM);
    addr[7:0] = sif.immByte;
    windowLo = sif.smallVariant ? oag_pkg::SHORT_LO_SMALL
                                : oag_pkg::SHORT_LO_LARGE;
    sif.shortAddr = addr;
    sif.inWindow  = (addr >= windowLo) && (addr <= oag_pkg::SHORT_HI);
    sif.aligned   = !sif.wordOp || !addr[0];
  end

endmodule

// *** verilog/oag_core.sv ***
// Purpose: Operand effective-address generator for an 8-bit core.
// Assumes: Decoded fields arrive with reqValid; pair contents are stable then.
// Notes:   One request per cycle; results appear one edge later.
module oag_core (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             reqValid,
  input  wire logic [7:0]       opcode,
  input  wire logic             opcodeValid,
  input  wire oag_pkg::oag_mode_t  mode,
  input  wire oag_pkg::oag_stack_t stackOp,
  input  wire logic [7:0]       immByte,
  input  wire logic [2:0]       regField,
  input  wire logic             pairIsBase,
  input  wire logic [1:0]       pairField,
  input  wire logic             wordOp,
  input  wire logic             smallVariant,
  input  wire logic [15:0]      pointer_pair,
  input  wire logic [15:0]      base_pair,
  input  wire logic [15:0]      stack_pointer,
  output logic [15:0]           effAddr,
  output logic                  addrValid,
  output logic                  addrFault,
  output logic                  regValid,
  output logic [2:0]            regNumber,
  output logic [1:0]            register_pair_operand,
  output logic                  loadAccum
);

  // ****************************************
  // Short direct former
  // ****************************************
  oag_short_if sif ();

  oag_short_former u_short (
    .sif (sif)
  );

  assign sif.immByte      = immByte;
  assign sif.smallVariant = smallVariant;
  assign sif.wordOp       = wordOp;

  // ****************************************
  // Request decode
  // ****************************************
  // Fixed accumulator load outranks any mode request in the same cycle
  logic takeLoad;
  logic takeReq;
  logic isShort;
  logic isSfr;
  logic isReg;
  logic isIndir;
  logic isBased;
  logic isStack;
  logic isBadMode;

  always_comb begin
    takeLoad  = opcodeValid && (opcode == oag_pkg::OPC_LOAD_ACC_PTR);
    takeReq   = reqValid && !takeLoad;
    isShort   = 1'b0;
    isSfr     = 1'b0;
    isReg     = 1'b0;
    isIndir   = 1'b0;
    isBased   = 1'b0;
    isStack   = 1'b0;
    isBadMode = 1'b0;
    if (takeReq) begin
      case (mode)
        oag_pkg::MODE_SHORT: begin
          isShort = 1'b1;
        end
        oag_pkg::MODE_SFR: begin
          isSfr = 1'b1;
        end
        oag_pkg::MODE_REG: begin
          isReg = 1'b1;
        end
        oag_pkg::MODE_INDIR: begin
          isIndir = 1'b1;
        end
        oag_pkg::MODE_BASED: begin
          isBased = 1'b1;
        end
        oag_pkg::MODE_STACK: begin
          isStack = 1'b1;
        end
        default: begin
          // Undefined mode codes are refused, never guessed
          isBadMode = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Register page address
  // ****************************************
  logic [15:0] sfrCand;
  logic        sfrOk;

  always_comb begin
    sfrCand = {oag_pkg::SFR_PAGE, immByte};
    // Lowest part of the page belongs to short direct
    sfrOk   = immByte > oag_pkg::SHORT_SFR_LIM;
  end

  // ****************************************
  // Pair addresses
  // ****************************************
  logic [15:0] indirCand;
  logic [1:0]  indirPair;
  logic [15:0] basedCand;

  always_comb begin
    indirCand = pairIsBase ? base_pair : pointer_pair;
    indirPair = pairIsBase ? oag_pkg::PAIR_BASE : oag_pkg::PAIR_POINTER;
    // Offset is zero-extended; the carry out of bit 15 is simply dropped
    basedCand = base_pair + {8'h00, immByte};
  end

  // ****************************************
  // Stack address
  // ****************************************
  // Multi-byte pushes are separate requests; the core moves the pointer
  logic [15:0] ramLo;
  logic        preDec;
  logic [15:0] stackCand;
  logic        stackOk;

  always_comb begin
    ramLo     = smallVariant ? oag_pkg::SHORT_LO_SMALL : oag_pkg::SHORT_LO_LARGE;
    // Pushes, calls and interrupt saves write below the current top
    preDec    = (stackOp == oag_pkg::STK_PUSH) || (stackOp == oag_pkg::STK_CALL) ||
                (stackOp == oag_pkg::STK_INT_SAVE);
    stackCand = preDec ? stack_pointer - oag_pkg::STACK_STEP : stack_pointer;
    // Stack outside fast RAM is refused rather than wrapped
    stackOk   = (stackCand >= ramLo) && (stackCand <= oag_pkg::FAST_RAM_HI);
  end

  // ****************************************
  // Effective address
  // ****************************************
  logic [15:0] effAddr_r;
  logic [15:0] effAddr_nxt;

  always_comb begin
    // Held when a request names no memory location
    effAddr_nxt = effAddr_r;
    if (takeLoad) begin
      effAddr_nxt = pointer_pair;
    end else if (isShort) begin
      effAddr_nxt = sif.shortAddr;
    end else if (isSfr) begin
      effAddr_nxt = sfrCand;
    end else if (isIndir) begin
      effAddr_nxt = indirCand;
    end else if (isBased) begin
      effAddr_nxt = basedCand;
    end else if (isStack) begin
      effAddr_nxt = stackCand;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      effAddr_r <= oag_pkg::ADDR_RST;
    end else begin
      effAddr_r <= effAddr_nxt;
    end
  end

  // ****************************************
  // Address status
  // ****************************************
  logic shortOk;
  logic addrValid_r;
  logic addrValid_nxt;
  logic addrFault_r;
  logic addrFault_nxt;

  always_comb begin
    shortOk = sif.inWindow && sif.aligned;
  end

  always_comb begin
    // Refused requests in a defined mode still show their address; only the status differs
    addrValid_nxt = 1'b0;
    addrFault_nxt = 1'b0;
    if (takeLoad) begin
      addrValid_nxt = 1'b1;
    end else if (isShort) begin
      addrValid_nxt = shortOk;
      addrFault_nxt = !shortOk;
    end else if (isSfr) begin
      addrValid_nxt = sfrOk;
      addrFault_nxt = !sfrOk;
    end else if (isIndir) begin
      addrValid_nxt = 1'b1;
    end else if (isBased) begin
      addrValid_nxt = 1'b1;
    end else if (isStack) begin
      addrValid_nxt = stackOk;
      addrFault_nxt = !stackOk;
    end else if (isBadMode) begin
      addrFault_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrValid_r <= 1'b0;
      addrFault_r <= 1'b0;
    end else begin
      addrValid_r <= addrValid_nxt;
      addrFault_r <= addrFault_nxt;
    end
  end

  // ****************************************
  // Register selection
  // ****************************************
  logic        regValid_r;
  logic        regValid_nxt;
  logic [2:0]  regNumber_r;
  logic [2:0]  regNumber_nxt;
  logic [1:0]  pair_r;
  logic [1:0]  pair_nxt;

  always_comb begin
    // Number and pair hold until another result names them
    regValid_nxt  = 1'b0;
    regNumber_nxt = regNumber_r;
    pair_nxt      = pair_r;
    if (takeLoad) begin
      // The fixed load reports the pair it read through
      pair_nxt      = oag_pkg::PAIR_POINTER;
    end else if (isReg) begin
      regValid_nxt  = 1'b1;
      regNumber_nxt = regField;
      pair_nxt      = pairField;
    end else if (isIndir) begin
      pair_nxt      = indirPair;
    end else if (isBased) begin
      pair_nxt      = oag_pkg::PAIR_BASE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regValid_r  <= 1'b0;
      regNumber_r <= oag_pkg::REG_RST;
      pair_r      <= oag_pkg::PAIR_ACCUM;
    end else begin
      regValid_r  <= regValid_nxt;
      regNumber_r <= regNumber_nxt;
      pair_r      <= pair_nxt;
    end
  end

  // ****************************************
  // Accumulator load
  // ****************************************
  logic loadAccum_r;
  logic loadAccum_nxt;

  always_comb begin
    // High for one cycle per decoded load; back-to-back loads hold it high without a gap
    loadAccum_nxt = takeLoad;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadAccum_r <= 1'b0;
    end else begin
      loadAccum_r <= loadAccum_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Straight from flops so the core never sees decode glitches
  assign effAddr               = effAddr_r;
  assign addrValid             = addrValid_r;
  assign addrFault             = addrFault_r;
  assign regValid              = regValid_r;
  assign regNumber             = regNumber_r;
  assign register_pair_operand = pair_r;
  assign loadAccum             = loadAccum_r;

endmodule

// *** verification/oag_core_asserts.sv ***
// Purpose: Port assertions for the operand address generator.
// Assumes: Each result shows one edge after its request edge.
// Notes:   Opcode 2B outranks reqValid in the same cycle.
module oag_core_chk (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                reqValid,
  input wire logic [7:0]          opcode,
  input wire logic                opcodeValid,
  input wire oag_pkg::oag_mode_t  mode,
  input wire oag_pkg::oag_stack_t stackOp,
  input wire logic [7:0]          immByte,
  input wire logic [2:0]          regField,
  input wire logic                pairIsBase,
  input wire logic [1:0]          pairField,
  input wire logic                wordOp,
  input wire logic                smallVariant,
  input wire logic [15:0]         pointer_pair,
  input wire logic [15:0]         base_pair,
  input wire logic [15:0]         stack_pointer,
  input wire logic [15:0]         effAddr,
  input wire logic                addrValid,
  input wire logic                addrFault,
  input wire logic                regValid,
  input wire logic [2:0]          regNumber,
  input wire logic [1:0]          register_pair_operand,
  input wire logic                loadAccum
);
  logic ld;
  logic tk;
  // Reset kept in both so nothing sampled inside reset counts as a request
  assign ld = rst_n && opcodeValid && opcode == 8'h2B;
  assign tk = rst_n && reqValid && !ld;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  short_addr_a: assert property ($past(tk && mode == oag_pkg::MODE_SHORT) |->
    effAddr == {7'h7F, $past(immByte) <= 8'h1F, $past(immByte)}) else $error("short address");
  small_window_a: assert property ($past(tk && mode == oag_pkg::MODE_SHORT &&
    smallVariant && immByte inside {[8'h20:8'h7F]}) |-> addrFault && !addrValid)
    else $error("small window");
  sfr_page_a: assert property ($past(tk && mode == oag_pkg::MODE_SFR) |->
    effAddr == {8'hFF, $past(immByte)} && addrFault == ($past(immByte) <= 8'h1F))
    else $error("register page");
  reg_select_a: assert property ($past(tk && mode == oag_pkg::MODE_REG) |-> regValid &&
    regNumber == $past(regField) && register_pair_operand == $past(pairField))
    else $error("register select");
  indir_addr_a: assert property ($past(tk && mode == oag_pkg::MODE_INDIR) |->
    effAddr == $past(pairIsBase ? base_pair : pointer_pair)) else $error("indirect address");
  load_ptr_a: assert property ($past(ld) |->
    loadAccum && effAddr == $past(pointer_pair)) else $error("pointer load");
  based_wrap_a: assert property ($past(tk && mode == oag_pkg::MODE_BASED) |->
    effAddr == $past(base_pair + {8'h00, immByte})) else $error("based address");
  // Pull codes are the odd ones and use the pointer as it stands
  stack_addr_a: assert property ($past(tk && mode == oag_pkg::MODE_STACK) |->
    effAddr == $past(stack_pointer - {15'h0000, !stackOp[0]})) else $error("stack address");
  cover property (ld);
  cover property (tk && mode == oag_pkg::MODE_STACK);
  cover property (addrFault);
endmodule

// *** verification/operand_address_generator_tb_top.sv ***
// Purpose: Directed bench for the operand address generator.
// Assumes: Each result shows one edge after its request.
// Notes:   Requests run back to back inside each test.
module operand_address_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, opcodeValid = 1'b0;
  logic                pairIsBase = 1'b0, wordOp = 1'b0, smallVariant = 1'b0;
  logic [7:0]          opcode = 8'h00, immByte = 8'h00;
  logic [2:0]          regField = 3'h0, regNumber;
  logic [1:0]          pairField = 2'h0, register_pair_operand;
  logic [15:0]         pointer_pair = 16'h0000, base_pair = 16'h0000, stack_pointer = 16'h0000;
  oag_pkg::oag_mode_t  mode = oag_pkg::MODE_SHORT;
  oag_pkg::oag_stack_t stackOp = oag_pkg::STK_PUSH;
  logic [15:0]         effAddr;
  logic                addrValid, addrFault, regValid, loadAccum;
  int                  fail_count = 0, samples_checked = 0, cycles = 0;
  logic [7:0]          imms [6] = '{8'h00, 8'h1F, 8'h20, 8'h7F, 8'h80, 8'hFF};
  oag_core dut (.core_clk, .rst_n, .reqValid, .opcode, .opcodeValid, .mode, .stackOp,
    .immByte, .regField, .pairIsBase, .pairField, .wordOp, .smallVariant, .pointer_pair,
    .base_pair, .stack_pointer, .effAddr, .addrValid, .addrFault, .regValid, .regNumber,
    .register_pair_operand, .loadAccum);
  initial forever #20 core_clk = ~core_clk;
  // Tests need under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Fields are set at the falling edge before this; the edge takes them
  task automatic fire();
    reqValid = 1'b1;
    @(posedge core_clk);
    #1;
  endtask
  task automatic t_short();
    logic [7:0] v;
    logic       bad;
    for (int k = 0; k < 12; k++) begin
      v = imms[k % 6];
      @(negedge core_clk);
      mode = oag_pkg::MODE_SHORT;
      smallVariant = k < 6;
      immByte = v;
      wordOp = k[1];
      fire();
      chk(effAddr, {7'h7F, v <= 8'h1F, v});
      bad = (k < 6 && v inside {[8'h20:8'h7F]}) || (k[1] && v[0]);
      chk(16'({addrFault, addrValid}), bad ? 16'h0002 : 16'h0001);
    end
    $display("short direct test done");
  endtask
  task automatic t_sfr();
    for (int k = 0; k < 6; k++) begin
      @(negedge core_clk);
      mode = oag_pkg::MODE_SFR;
      immByte = imms[k];
      fire();
      chk(effAddr, {8'hFF, imms[k]});
      chk(16'(addrFault), 16'(imms[k] <= 8'h1F));
    end
    $display("register page test done");
  endtask
  task automatic t_reg();
    for (int r = 0; r < 8; r++) begin
      @(negedge core_clk);
      mode = oag_pkg::MODE_REG;
      regField = r[2:0];
      pairField = r[1:0];
      fire();
      chk(16'({regValid, regNumber}), 16'(r + 8));
      chk(16'(register_pair_operand), 16'(r % 4));
    end
    $display("register test done");
  endtask
  task automatic t_ptr();
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      mode = oag_pkg::MODE_INDIR;
      pointer_pair = 16'h1234;
      base_pair = 16'hABCD;
      pairIsBase = k[0];
      fire();
      chk(effAddr, k ? 16'hABCD : 16'h1234);
    end
    @(negedge core_clk);
    mode = oag_pkg::MODE_SFR;
    opcodeValid = 1'b1;
    opcode = 8'h2B;
    fire();
    chk(16'({loadAccum, addrFault, register_pair_operand}), 16'h000A);
    chk(effAddr, 16'h1234);
    @(negedge core_clk);
    opcodeValid = 1'b0;
    mode = oag_pkg::MODE_BASED;
    base_pair = 16'hFFF0;
    immByte = 8'hF0;
    fire();
    chk(effAddr, 16'h00E0);
    $display("pair test done");
  endtask
  task automatic t_stack();
    logic [15:0] a;
    for (int k = 0; k < 12; k++) begin
      a = (k < 6 ? 16'hFE80 : 16'hFF00) - {15'h0000, !k[0]};
      @(negedge core_clk);
      mode = oag_pkg::MODE_STACK;
      stackOp = oag_pkg::oag_stack_t'(3'(k % 6));
      stack_pointer = k < 6 ? 16'hFE80 : 16'hFF00;
      smallVariant = k < 6;
      fire();
      chk(effAddr, a);
      chk(16'(addrValid), 16'(a <= 16'hFEFF && a >= (k < 6 ? 16'hFE80 : 16'hFE20)));
    end
    $display("stack test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_short();
    t_sfr();
    t_reg();
    t_ptr();
    t_stack();
    @(negedge core_clk);
    reqValid = 1'b0;
    @(posedge core_clk);
    complete_run();
  end
endmodule
bind oag_core oag_core_chk chk (.core_clk, .rst_n, .reqValid, .opcode, .opcodeValid, .mode,
  .stackOp, .immByte, .regField, .pairIsBase, .pairField, .wordOp, .smallVariant, .pointer_pair,
  .base_pair, .stack_pointer, .effAddr, .addrValid, .addrFault, .regValid, .regNumber,
  .register_pair_operand, .loadAccum);
